/* design/bovs_regs.svh */
`ifndef BOVS_REGS_SVH
`define BOVS_REGS_SVH

// register byte offsets
`define BOVS_CTRL_OFS 12'h000
`define BOVS_TARGET_OFS 12'h004
`define BOVS_PROT_OFS 12'h008
`define BOVS_STATUS_OFS 12'h00C
`define BOVS_TRIPCNT_OFS 12'h010

// field positions
`define BOVS_CTRL_EN_BIT 0
`define BOVS_CTRL_SLOPE_LSB 1
`define BOVS_PROT_MARGIN_LSB 0
`define BOVS_PROT_HYST_LSB 4
`define BOVS_STAT_OV_BIT 0
`define BOVS_STAT_REG_BIT 1
`define BOVS_STAT_TRIP_BIT 2
`define BOVS_STAT_GATE_BIT 3

// reset values
`define BOVS_EN_RST 1'h0
`define BOVS_TARGET_RST 7'h00
`define BOVS_MARGIN_RST 3'h0
`define BOVS_HYST_RST 2'h0
`define BOVS_SLOPE_RST 2'h0
`define BOVS_OV_FLAG_RST 1'h1
`define BOVS_STATUS_RST 1'h1
`define BOVS_TRIPCNT_RST 8'h00

`endif

/* design/bovs_pkg.sv */
package bovs_pkg;

    // protection state of the gate path
    typedef enum logic [1:0] {
        BOVS_RUN = 2'b00,
        BOVS_TRIP = 2'b01,
        BOVS_REARM = 2'b10
    } bovs_state_e;

    // slope compensation choices, zero switches it off
    typedef enum logic [1:0] {
        BOVS_SLOPE_OFF = 2'b00,
        BOVS_SLOPE_LOW = 2'b01,
        BOVS_SLOPE_MID = 2'b10,
        BOVS_SLOPE_HIGH = 2'b11
    } bovs_slope_e;

    // comparator and timing inputs, raw or synchronised
    typedef struct packed {
        logic ov;
        logic react;
        logic lowfb;
        logic gate_req;
        logic cycle;
    } bovs_cmp_s;

endpackage : bovs_pkg

/* design/bovs_sync.sv */
module bovs_sync (
    input wire logic clk, // core clock
    input wire logic rst, // synchronous reset, active high
    input wire bovs_pkg::bovs_cmp_s async_in, // raw comparator levels
    output bovs_pkg::bovs_cmp_s sync_out // synchronised levels
);

    bovs_pkg::bovs_cmp_s meta_reg;
    bovs_pkg::bovs_cmp_s sync_reg;

    // two flip-flop synchroniser, first stage read only by second
    always_ff @(posedge clk) begin
        if (rst) begin
            meta_reg <= '0;
            sync_reg <= '0;
        end else begin
            meta_reg <= async_in;
            sync_reg <= meta_reg;
        end
    end

    assign sync_out = sync_reg;

endmodule : bovs_sync

/* design/bovs_ovp.sv */
module bovs_ovp (
    input wire logic clk, // core clock
    input wire logic rst, // synchronous reset, active high
    input wire logic trip_now, // overvoltage or lost feedback, synchronised
    input wire logic below_react, // voltage under reactivation level
    input wire logic cycle_start, // one-cycle pulse at pwm period start
    output logic pwm_allow, // gate may follow the current loop
    output logic trip_pulse, // one-cycle pulse on entering trip
    output logic tripped // protection holding the gate off
);

    bovs_pkg::bovs_state_e state_reg;
    bovs_pkg::bovs_state_e state_next;

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            bovs_pkg::BOVS_RUN: begin
                if (trip_now) begin
                    state_next = bovs_pkg::BOVS_TRIP;
                end
            end
            bovs_pkg::BOVS_TRIP: begin
                if (!trip_now && below_react) begin
                    state_next = bovs_pkg::BOVS_REARM;
                end
            end
            bovs_pkg::BOVS_REARM: begin
                if (trip_now || !below_react) begin
                    state_next = bovs_pkg::BOVS_TRIP;
                end else if (cycle_start) begin
                    state_next = bovs_pkg::BOVS_RUN;
                end
            end
            default: begin
                state_next = bovs_pkg::BOVS_TRIP;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg <= bovs_pkg::BOVS_RUN;
        end else begin
            state_reg <= state_next;
        end
    end

    // gate cut in the very cycle the trip is seen
    assign pwm_allow = (state_reg == bovs_pkg::BOVS_RUN) && !trip_now;
    assign trip_pulse = (state_reg == bovs_pkg::BOVS_RUN) && trip_now;
    assign tripped = (state_reg != bovs_pkg::BOVS_RUN);

endmodule : bovs_ovp

/* design/bovs_top.sv */
// Contract
// - Hold a 7-bit target code setting boost output from 11 V up to 64.1 V.
// - After power-up the booster is disabled and the target code is zero.
// - Above target plus 3-bit margin, gate drive is off for rest of cycle.
// - A trip sets the overvoltage flag and clears the regulation status.
// - Gate stays off until below reactivation level, then resumes, status 1.
// - Flag stays set; a read while below reactivation level clears it; here only once back in BOVS_RUN, not in BOVS_REARM.
// - Flag may read set on first read after reset; host discards it.
// - Detection and flag updates run even while the booster is disabled.
// - Later variant: low feedback voltage raises the flag and stops boost.
// - A 2-bit slope compensation select; one code disables it.
// - Gate pwm only while enable bit is 1; else gate held off.
`include "bovs_regs.svh"

module bovs_top #(
    parameter bit LOWFB_DETECT = 1'b1 // later variant with feedback loss check
) (
    input wire logic clk, // core clock, 100 MHz
    input wire logic rst, // synchronous reset, active high
    input wire logic [11:0] paddr, // apb address
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb direction, high for write
    input wire logic [31:0] pwdata, // apb write data
    input wire logic [3:0] pstrb, // apb byte strobes
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error
    input wire logic ov_cmp_in, // comparator: above target plus margin
    input wire logic react_cmp_in, // comparator: below reactivation level
    input wire logic lowfb_cmp_in, // comparator: feedback voltage too low
    input wire logic gate_req_in, // current loop gate request
    input wire logic pwm_clk_in, // pwm period clock, rise starts a cycle
    output logic gate_drive_out, // boost mosfet gate drive
    output logic [6:0] boost_target_code, // target code to reference dac
    output logic [2:0] overvoltage_margin, // margin to trip comparator
    output logic [1:0] reactivation_hysteresis, // hysteresis to comparator
    output logic [1:0] slope_comp_select // slope compensation select
);

    // ********************************************************
    // functions
    // ********************************************************

    // true when the address hits a mapped register
    function automatic logic addr_mapped(input logic [11:0] addr);
        logic hit;
        hit = 1'b0;
        case (addr)
            `BOVS_CTRL_OFS: hit = 1'b1;
            `BOVS_TARGET_OFS: hit = 1'b1;
            `BOVS_PROT_OFS: hit = 1'b1;
            `BOVS_STATUS_OFS: hit = 1'b1;
            `BOVS_TRIPCNT_OFS: hit = 1'b1;
            default: hit = 1'b0;
        endcase
        return hit;
    endfunction : addr_mapped

    // true when the address is read only
    function automatic logic addr_read_only(input logic [11:0] addr);
        return (addr == `BOVS_STATUS_OFS) || (addr == `BOVS_TRIPCNT_OFS);
    endfunction : addr_read_only

    // error for an unmapped address or a write to a read-only register
    function automatic logic bus_error(input logic [11:0] addr, input logic is_write);
        return !addr_mapped(addr) || (is_write && addr_read_only(addr));
    endfunction : bus_error

    // saturating increment of an eight-bit count
    function automatic logic [7:0] sat_inc(input logic [7:0] value);
        return (value == 8'hFF) ? value : value + 8'h01;
    endfunction : sat_inc

    // ********************************************************
    // declarations
    // ********************************************************

    logic enable_reg;
    logic [6:0] target_reg;
    logic [2:0] margin_reg;
    logic [1:0] hyst_reg;
    logic [1:0] slope_reg;
    logic ov_flag_reg;
    logic status_reg;
    logic gate_reg;
    logic [7:0] trip_cnt_reg;
    logic [31:0] prdata_reg;
    logic pready_reg;
    logic pslverr_reg;
    logic cycle_prev_reg;

    bovs_pkg::bovs_cmp_s cmp_raw;
    bovs_pkg::bovs_cmp_s cmp_sync;

    logic access;
    logic done;
    logic wr_ok;
    logic rd_status;
    logic lowfb_trip;
    logic trip_now;
    logic below_react;
    logic cycle_start;
    logic pwm_allow;
    logic trip_pulse;
    logic tripped;
    logic [31:0] rd_value;
    logic wr_ctrl;
    logic wr_target;
    logic wr_prot;
    logic rd_clear;
    logic gate_next;
    logic ov_flag_next;
    logic status_next;
    logic [7:0] trip_cnt_next;

    // ********************************************************
    // comparator synchronisation
    // ********************************************************

    assign cmp_raw.ov = ov_cmp_in;
    assign cmp_raw.react = react_cmp_in;
    assign cmp_raw.lowfb = lowfb_cmp_in;
    assign cmp_raw.gate_req = gate_req_in;
    assign cmp_raw.cycle = pwm_clk_in;

    bovs_sync u_sync (
        .clk(clk),
        .rst(rst),
        .async_in(cmp_raw),
        .sync_out(cmp_sync)
    );

    // rising edge of the synchronised period clock
    always_ff @(posedge clk) begin
        if (rst) begin
            cycle_prev_reg <= 1'b0;
        end else begin
            cycle_prev_reg <= cmp_sync.cycle;
        end
    end

    assign cycle_start = cmp_sync.cycle && !cycle_prev_reg;

    // ********************************************************
    // overvoltage protection
    // ********************************************************

    // lost feedback acts as an overvoltage trip
    assign lowfb_trip = LOWFB_DETECT && cmp_sync.lowfb;
    assign trip_now = cmp_sync.ov || lowfb_trip;
    assign below_react = cmp_sync.react && !trip_now;

    // runs whatever the enable bit says
    bovs_ovp u_ovp (
        .clk(clk),
        .rst(rst),
        .trip_now(trip_now),
        .below_react(below_react),
        .cycle_start(cycle_start),
        .pwm_allow(pwm_allow),
        .trip_pulse(trip_pulse),
        .tripped(tripped)
    );

    // ********************************************************
    // gate drive
    // ********************************************************

    assign gate_next = enable_reg && pwm_allow && cmp_sync.gate_req;

    always_ff @(posedge clk) begin
        if (rst) begin
            gate_reg <= 1'b0;
        end else begin
            gate_reg <= gate_next;
        end
    end

    // ********************************************************
    // apb handshake
    // ********************************************************

    assign access = psel && penable;
    assign done = access && pready_reg;
    assign wr_ok = done && pwrite && pstrb[0] && addr_mapped(paddr)
        && !addr_read_only(paddr);
    assign rd_status = done && !pwrite && (paddr == `BOVS_STATUS_OFS);

    // register selects, taken only at the completing edge
    assign wr_ctrl = wr_ok && (paddr == `BOVS_CTRL_OFS);
    assign wr_target = wr_ok && (paddr == `BOVS_TARGET_OFS);
    assign wr_prot = wr_ok && (paddr == `BOVS_PROT_OFS);

    // one wait state, then ready for a single cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            pready_reg <= 1'b0;
        end else begin
            pready_reg <= access && !pready_reg;
        end
    end

    // error for unmapped address or write to read-only register
    always_ff @(posedge clk) begin
        if (rst) begin
            pslverr_reg <= 1'b0;
        end else if (access && !pready_reg) begin
            pslverr_reg <= bus_error(paddr, pwrite);
        end else begin
            pslverr_reg <= 1'b0;
        end
    end

    // ********************************************************
    // configuration registers
    // ********************************************************

    always_ff @(posedge clk) begin
        if (rst) begin
            enable_reg <= `BOVS_EN_RST;
            slope_reg <= `BOVS_SLOPE_RST;
        end else if (wr_ctrl) begin
            enable_reg <= pwdata[`BOVS_CTRL_EN_BIT];
            slope_reg <= pwdata[`BOVS_CTRL_SLOPE_LSB +: 2];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            target_reg <= `BOVS_TARGET_RST;
        end else if (wr_target) begin
            target_reg <= pwdata[6:0];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            margin_reg <= `BOVS_MARGIN_RST;
            hyst_reg <= `BOVS_HYST_RST;
        end else if (wr_prot) begin
            margin_reg <= pwdata[`BOVS_PROT_MARGIN_LSB +: 3];
            hyst_reg <= pwdata[`BOVS_PROT_HYST_LSB +: 2];
        end
    end

    // ********************************************************
    // status flags
    // ********************************************************

    // a status read clears the flag only once the voltage is back down
    assign rd_clear = rd_status && below_react && !tripped;

    // sticky flag, set wins over the read clear
    always_comb begin
        ov_flag_next = ov_flag_reg;
        if (trip_pulse || (tripped && trip_now)) begin
            ov_flag_next = 1'b1;
        end else if (rd_clear) begin
            ov_flag_next = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ov_flag_reg <= `BOVS_OV_FLAG_RST;
        end else begin
            ov_flag_reg <= ov_flag_next;
        end
    end

    // regulation status follows the protection state
    assign status_next = !tripped && !trip_now;

    always_ff @(posedge clk) begin
        if (rst) begin
            status_reg <= `BOVS_STATUS_RST;
        end else begin
            status_reg <= status_next;
        end
    end

    // saturating count of trips
    assign trip_cnt_next = sat_inc(trip_cnt_reg);

    always_ff @(posedge clk) begin
        if (rst) begin
            trip_cnt_reg <= `BOVS_TRIPCNT_RST;
        end else if (trip_pulse) begin
            trip_cnt_reg <= trip_cnt_next;
        end
    end

    // ********************************************************
    // read data
    // ********************************************************

    always_comb begin
        rd_value = 32'h0000_0000;
        case (paddr)
            `BOVS_CTRL_OFS: begin
                rd_value[`BOVS_CTRL_EN_BIT] = enable_reg;
                rd_value[`BOVS_CTRL_SLOPE_LSB +: 2] = slope_reg;
            end
            `BOVS_TARGET_OFS: begin
                rd_value[6:0] = target_reg;
            end
            `BOVS_PROT_OFS: begin
                rd_value[`BOVS_PROT_MARGIN_LSB +: 3] = margin_reg;
                rd_value[`BOVS_PROT_HYST_LSB +: 2] = hyst_reg;
            end
            `BOVS_STATUS_OFS: begin
                rd_value[`BOVS_STAT_OV_BIT] = ov_flag_reg;
                rd_value[`BOVS_STAT_REG_BIT] = status_reg;
                rd_value[`BOVS_STAT_TRIP_BIT] = tripped;
                rd_value[`BOVS_STAT_GATE_BIT] = gate_reg;
            end
            `BOVS_TRIPCNT_OFS: begin
                rd_value[7:0] = trip_cnt_reg;
            end
            default: begin
                rd_value = 32'h0000_0000;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            prdata_reg <= 32'h0000_0000;
        end else if (access && !pready_reg && !pwrite) begin
            prdata_reg <= rd_value;
        end else begin
            prdata_reg <= 32'h0000_0000;
        end
    end

    // ********************************************************
    // outputs
    // ********************************************************

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign gate_drive_out = gate_reg;
    assign boost_target_code = target_reg;
    assign overvoltage_margin = margin_reg;
    assign reactivation_hysteresis = hyst_reg;
    assign slope_comp_select = slope_reg;

endmodule : bovs_top

/* tb/bovs_asserts.sv */
`include "bovs_regs.svh"

module bovs_top_chk #(
    parameter bit LOWFB_DETECT = 1'b1 // lost feedback check present
) (
    input wire logic clk, // core clock
    input wire logic rst, // sync reset
    input wire logic [11:0] paddr, // apb address
    input wire logic psel, // apb select
    input wire logic penable, // apb access
    input wire logic pwrite, // apb direction
    input wire logic [31:0] pwdata, // apb write data
    input wire logic [3:0] pstrb, // apb strobes
    input wire logic [31:0] prdata, // apb read data
    input wire logic pready, // apb ready
    input wire logic pslverr, // apb error
    input wire logic ov_cmp_in, // overvoltage comparator
    input wire logic react_cmp_in, // reactivation comparator
    input wire logic lowfb_cmp_in, // low feedback comparator
    input wire logic gate_req_in, // loop gate request
    input wire logic pwm_clk_in, // pwm period clock
    input wire logic gate_drive_out, // gate drive
    input wire logic [6:0] boost_target_code, // target code
    input wire logic [2:0] overvoltage_margin, // trip margin
    input wire logic [1:0] reactivation_hysteresis, // hysteresis
    input wire logic [1:0] slope_comp_select // slope select
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************
    // completed writes tracked from the bus
    // ****************************************
    logic en_q;
    logic [31:0] pw_q;
    logic wr_ok;
    assign wr_ok = psel && penable && pready && pwrite && pstrb[0];
    always_ff @(posedge clk) begin
        pw_q <= pwdata;
        if (rst) begin
            en_q <= 1'b0;
        end else if (wr_ok && paddr == `BOVS_CTRL_OFS) begin
            en_q <= pwdata[0];
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    reset_values_a: assert property ($fell(rst) |-> boost_target_code == 7'h00
        && !gate_drive_out) else $error("config or gate not cleared by reset");
    target_write_a: assert property (wr_ok && paddr == `BOVS_TARGET_OFS
        |=> boost_target_code == pw_q[6:0]) else $error("target code not written");
    slope_write_a: assert property (wr_ok && paddr == `BOVS_CTRL_OFS
        |=> slope_comp_select == pw_q[2:1]) else $error("slope select not written");
    prot_write_a: assert property (wr_ok && paddr == `BOVS_PROT_OFS |=>
        overvoltage_margin == pw_q[2:0] && reactivation_hysteresis == pw_q[5:4])
        else $error("margin or hysteresis not written");
    gate_off_a: assert property (!en_q && !$past(en_q) |-> !gate_drive_out)
        else $error("gate driven while booster disabled");
    trip_gate_a: assert property (ov_cmp_in [*4] |=> !gate_drive_out)
        else $error("gate still driven during overvoltage");
    lowfb_gate_a: assert property ((lowfb_cmp_in && LOWFB_DETECT) [*4]
        |=> !gate_drive_out) else $error("gate still driven with feedback lost");
    trip_flags_a: assert property (ov_cmp_in [*6] ##0 (psel && penable && pready
        && !pwrite && paddr == `BOVS_STATUS_OFS) |-> prdata[1:0] == 2'b01)
        else $error("trip flags wrong in status read");
    trip_cv: cover property (ov_cmp_in [*4] ##1 !gate_drive_out);
    resume_cv: cover property ($rose(gate_drive_out));
    flag_cv: cover property (pready && paddr == `BOVS_STATUS_OFS && prdata[0]);
endmodule : bovs_top_chk

bind bovs_top bovs_top_chk #(.LOWFB_DETECT(LOWFB_DETECT)) u_chk (.*);

/* tb/bovs_host.sv */
module bovs_host (
    input wire logic clk, // core clock
    input wire logic pready, // apb ready
    input wire logic [31:0] prdata, // apb read data
    input wire logic pslverr, // apb error
    output logic [11:0] paddr, // apb address
    output logic psel, // apb select
    output logic penable, // apb access
    output logic pwrite, // apb direction
    output logic [31:0] pwdata, // apb write data
    output logic [3:0] pstrb // apb strobes
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************
    // apb master transfer
    // ****************************************
    initial begin
        paddr = 12'h000;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        pwdata = 32'h00000000;
        pstrb = 4'hF;
    end
    task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d,
                        output logic [31:0] q, output logic e);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) begin
            @(posedge clk);
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : xfer
endmodule : bovs_host

/* tb/tb_top.sv */
`include "bovs_regs.svh"

module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [11:0] paddr;
    logic psel, penable, pwrite, pready, pslverr, gate_drive_out, pwm_clk_in;
    logic [31:0] pwdata, prdata;
    logic [3:0] pstrb;
    logic [6:0] boost_target_code;
    logic [2:0] overvoltage_margin;
    logic [1:0] reactivation_hysteresis, slope_comp_select;
    logic ov_cmp_in = 1'b0;
    logic react_cmp_in = 1'b1;
    logic lowfb_cmp_in = 1'b0;
    logic gate_req_in = 1'b1;
    logic [3:0] pwm_cnt = 4'h0;
    int fail_count = 0;
    int checked = 0;
    assign pwm_clk_in = pwm_cnt[3];
    always #5 clk = ~clk;
    always @(posedge clk) begin
        pwm_cnt <= pwm_cnt + 4'h1;
    end
    bovs_top u_dut (.*);
    bovs_host u_host (.*);
    // ****************************************
    // check and access tasks
    // ****************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        u_host.xfer(a, 1'b1, d, q, e);
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] x);
        logic [31:0] q;
        logic e;
        u_host.xfer(a, 1'b0, 32'h00000000, q, e);
        chk(q & m, x);
    endtask : rd
    task automatic conclude();
        if (fail_count == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : conclude
    initial begin
        logic [31:0] q;
        logic e;
        cyc(12);
        rst <= 1'b0;
        rd(`BOVS_CTRL_OFS, 32'hFFFFFFFF, 32'h0);
        rd(`BOVS_TARGET_OFS, 32'hFFFFFFFF, 32'h0);
        chk({31'h0, gate_drive_out}, 32'h0);
        rd(`BOVS_STATUS_OFS, 32'h2, 32'h2);
        rd(`BOVS_STATUS_OFS, 32'h1, 32'h0);
        wr(`BOVS_TARGET_OFS, 32'hFFFFFFFF);
        rd(`BOVS_TARGET_OFS, 32'hFFFFFFFF, 32'h7F);
        chk({25'h0, boost_target_code}, 32'h7F);
        for (int i = 0; i < 4; i++) begin
            wr(`BOVS_CTRL_OFS, i << 1);
            chk({30'h0, slope_comp_select}, i);
        end
        wr(`BOVS_PROT_OFS, 32'h25);
        rd(`BOVS_PROT_OFS, 32'hFFFFFFFF, 32'h25);
        chk({27'h0, reactivation_hysteresis, overvoltage_margin}, 32'h15);
        wr(`BOVS_CTRL_OFS, 32'h1);
        cyc(24);
        chk({31'h0, gate_drive_out}, 32'h1);
        ov_cmp_in <= 1'b1;
        react_cmp_in <= 1'b0;
        cyc(5);
        chk({31'h0, gate_drive_out}, 32'h0);
        rd(`BOVS_STATUS_OFS, 32'h3, 32'h1);
        ov_cmp_in <= 1'b0;
        cyc(40);
        chk({31'h0, gate_drive_out}, 32'h0);
        react_cmp_in <= 1'b1;
        cyc(24);
        chk({31'h0, gate_drive_out}, 32'h1);
        rd(`BOVS_STATUS_OFS, 32'h3, 32'h3);
        rd(`BOVS_STATUS_OFS, 32'h1, 32'h0);
        wr(`BOVS_CTRL_OFS, 32'h0);
        cyc(3);
        chk({31'h0, gate_drive_out}, 32'h0);
        ov_cmp_in <= 1'b1;
        react_cmp_in <= 1'b0;
        cyc(5);
        rd(`BOVS_STATUS_OFS, 32'h3, 32'h1);
        ov_cmp_in <= 1'b0;
        react_cmp_in <= 1'b1;
        cyc(24);
        rd(`BOVS_STATUS_OFS, 32'h1, 32'h1);
        rd(`BOVS_STATUS_OFS, 32'h1, 32'h0);
        wr(`BOVS_CTRL_OFS, 32'h1);
        cyc(24);
        lowfb_cmp_in <= 1'b1;
        cyc(5);
        chk({31'h0, gate_drive_out}, 32'h0);
        rd(`BOVS_STATUS_OFS, 32'h3, 32'h1);
        lowfb_cmp_in <= 1'b0;
        cyc(24);
        chk({31'h0, gate_drive_out}, 32'h1);
        rd(`BOVS_TRIPCNT_OFS, 32'hFF, 32'h3);
        u_host.xfer(`BOVS_TRIPCNT_OFS, 1'b1, 32'h00000000, q, e);
        chk({31'h0, e}, 32'h1);
        rd(`BOVS_TRIPCNT_OFS, 32'hFF, 32'h3);
        u_host.xfer(12'h014, 1'b0, 32'h00000000, q, e);
        chk({31'h0, e}, 32'h1);
        chk(q, 32'h0);
        conclude();
    end
    initial begin
        cyc(4000);
        fail_count++;
        conclude();
    end
endmodule : tb_top
